// ---- design/ddmr_avg_if.sv ----
// Interface between the monitor top and its power averager
`timescale 1ns/1ps
interface ddmr_avg_if;
  logic sample_stb;
  logic [11:0] sample;
  logic long_avg;
  logic result_stb;
  logic [11:0] result;
  modport src (output sample_stb, sample, long_avg, input result_stb, result);
  modport avg (input sample_stb, sample, long_avg, output result_stb, result);
endinterface

// ---- design/ddmr_monitor.sv ----
// Diagnostics result reporting, fault masking and loopback top
// How it works
// - Supply voltages are unsigned 12-bit codes
// - Select 0 reports DC plus modulation over 3.2
// - DC and modulation currents from offset settings
// - Select 1 reports DC plus 1.9375 modulation
// - DC report ranges 17 to 1199
// - Average report ranges 43 to 2056
// - Laser report frozen while transmitter shut down
// - Power result clamped 32 to 4080
// - Sample every 100 ns, average 32/256
// - Results update every 10 or 40 ms
// - Unsigned results clamp negative inputs to zero
// - Temperature: signed integer byte, fraction byte
// - Sourced strength current sets low fail flag
// - Loopback paths transmit-to-receive and receive-to-laser
// - Squelch blocks outputs without input signal
// - Faults recorded in two status registers, maskable
// - Masked faults flag but cause no condition
// - Unmasked fault shuts transmitter unless globally masked
`timescale 1ns/1ps
module ddmr_monitor #(
  parameter int UPDATE_CYCLES = ddmr_pkg::UPDATE_CYC,
  parameter int STARTUP_CYCLES = ddmr_pkg::STARTUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic adc_valid,
  input wire logic [2:0] adc_chan,
  input wire logic signed [16:0] adc_data,
  input wire logic [11:0] monitor_diode_input,
  input wire logic rssi_sourcing,
  input wire logic [15:0] fault_ind,
  input wire logic disable_pin,
  input wire logic tx_input,
  input wire logic rx_input,
  input wire logic tx_sig_present,
  input wire logic rx_sig_present,
  output logic rx_output,
  output logic laser_anode_out,
  output logic laser_cathode_out,
  output logic tx_shutdown_status_bit,
  output logic strength_low_fail_flag
);

  localparam int UW = $clog2(UPDATE_CYCLES + 1);
  localparam int SW = $clog2(STARTUP_CYCLES + 1);

  ddmr_avg_if avg_bus ();

  logic [7:0] mode_control_reg;
  logic [7:0] fault_mask_one;
  logic [7:0] fault_mask_two;
  logic [7:0] tx_fault_status_one;
  logic [7:0] tx_fault_status_two;
  logic [7:0] ctrl;
  logic [7:0] loop_ctrl;
  logic [9:0] dc_current_setting;
  logic [8:0] modulation_setting;
  logic signed [16:0] latest [ddmr_pkg::NUM_ADC];
  logic signed [18:0] acc [ddmr_pkg::NUM_ADC];
  logic [15:0] result [ddmr_pkg::NUM_ADC];
  logic [15:0] res_view [ddmr_pkg::NUM_RES];
  logic [11:0] laser_current_report;
  logic [15:0] snap;
  logic [UW-1:0] upd_cnt;
  logic upd_tick;
  logic [1:0] avg_cnt;
  logic [SW-1:0] start_cnt;
  logic [3:0] smp_cnt;
  logic disable_d;
  logic restart_req;
  logic fault_cond;
  logic next_shutdown;
  ddmr_pkg::ddmr_tx_state_t tx_state;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] fit(input logic signed [18:0] v, input int ch);
    logic [15:0] r;
    r = v[15:0];
    if (ch == ddmr_pkg::CH_DIE || ch == ddmr_pkg::CH_REMOTE) begin
      if (v > 19'sh07fff) begin
        r = 16'h7fff;
      end else if (v < -19'sh08000) begin
        r = 16'h8000;
      end
    end else if (v < 19'sh00000) begin
      r = 16'h0000;
    end else if (ch == ddmr_pkg::CH_RSSI) begin
      if (v > 19'sh0ffff) begin
        r = 16'hffff;
      end
    end else if (v > 19'sh00fff) begin
      r = 16'h0fff;
    end
    return r;
  endfunction

  function automatic logic is_result(input logic [7:0] a);
    return a >= ddmr_pkg::A_RES_BASE && a < ddmr_pkg::A_RES_BASE + 8'(2 * ddmr_pkg::NUM_RES);
  endfunction

  function automatic logic [3:0] res_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - ddmr_pkg::A_RES_BASE;
    return d[4:1];
  endfunction

  // ==========================================================
  // Result view
  always_comb begin
    for (int i = 0; i < ddmr_pkg::NUM_ADC; i++) begin
      res_view[i] = result[i];
    end
    res_view[ddmr_pkg::RES_LASER] = {4'h0, laser_current_report};
    res_view[ddmr_pkg::RES_TXP] = {4'h0, avg_bus.result};
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_control_reg <= ddmr_pkg::MODE_RST;
      fault_mask_one <= ddmr_pkg::FMASK1_RST;
      fault_mask_two <= ddmr_pkg::FMASK2_RST;
      ctrl <= ddmr_pkg::CTRL_RST;
      loop_ctrl <= ddmr_pkg::LOOP_RST;
      dc_current_setting <= ddmr_pkg::DC_RST;
      modulation_setting <= ddmr_pkg::MOD_RST;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        ddmr_pkg::A_MODE: mode_control_reg <= reg_wdata;
        ddmr_pkg::A_FMASK1: fault_mask_one <= reg_wdata;
        ddmr_pkg::A_FMASK2: fault_mask_two <= reg_wdata;
        ddmr_pkg::A_CTRL: ctrl <= reg_wdata;
        ddmr_pkg::A_LOOP: loop_ctrl <= reg_wdata;
        ddmr_pkg::A_DC_HI: dc_current_setting[9:8] <= reg_wdata[1:0];
        ddmr_pkg::A_DC_LO: dc_current_setting[7:0] <= reg_wdata;
        ddmr_pkg::A_MOD_HI: modulation_setting[8] <= reg_wdata[0];
        ddmr_pkg::A_MOD_LO: modulation_setting[7:0] <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Read port with pair snapshot
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      snap <= 16'h0000;
    end else if (ce && reg_rd) begin
      reg_rdata <= 8'h00;
      if (is_result(reg_addr)) begin
        if (!reg_addr[0]) begin
          reg_rdata <= res_view[res_index(reg_addr)][15:8];
          snap <= res_view[res_index(reg_addr)];
        end else begin
          // Lower byte comes from the snapshot so an update cannot split the pair
          reg_rdata <= snap[7:0];
        end
      end else begin
        unique case (reg_addr)
          ddmr_pkg::A_MODE: reg_rdata <= mode_control_reg;
          ddmr_pkg::A_FMASK1: reg_rdata <= fault_mask_one;
          ddmr_pkg::A_FMASK2: reg_rdata <= fault_mask_two;
          ddmr_pkg::A_FSTAT1: reg_rdata <= tx_fault_status_one;
          ddmr_pkg::A_FSTAT2: reg_rdata <= tx_fault_status_two;
          ddmr_pkg::A_CTRL: reg_rdata <= ctrl;
          ddmr_pkg::A_LOOP: reg_rdata <= loop_ctrl;
          ddmr_pkg::A_DC_HI: reg_rdata <= {6'h00, dc_current_setting[9:8]};
          ddmr_pkg::A_DC_LO: reg_rdata <= dc_current_setting[7:0];
          ddmr_pkg::A_MOD_HI: reg_rdata <= {7'h00, modulation_setting[8]};
          ddmr_pkg::A_MOD_LO: reg_rdata <= modulation_setting[7:0];
          ddmr_pkg::A_DDM_STAT: begin
            reg_rdata[ddmr_pkg::B_STRENGTH_FAIL] <= strength_low_fail_flag;
            reg_rdata[ddmr_pkg::B_SHDN] <= tx_shutdown_status_bit;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Sticky status, cleared on read; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_fault_status_one <= 8'h00;
      tx_fault_status_two <= 8'h00;
      strength_low_fail_flag <= 1'b0;
    end else if (ce) begin
      // Masks are not applied here: a masked fault still flags
      tx_fault_status_one <= ((reg_rd && reg_addr == ddmr_pkg::A_FSTAT1) ?
                              8'h00 : tx_fault_status_one) | fault_ind[7:0];
      tx_fault_status_two <= ((reg_rd && reg_addr == ddmr_pkg::A_FSTAT2) ?
                              8'h00 : tx_fault_status_two) | fault_ind[15:8];
      strength_low_fail_flag <= ((reg_rd && reg_addr == ddmr_pkg::A_DDM_STAT) ?
                                 1'b0 : strength_low_fail_flag) | rssi_sourcing;
    end
  end

  // ==========================================================
  // Fault condition and transmitter state
  assign fault_cond = |(fault_ind & ~{fault_mask_two, fault_mask_one})
                      && !ctrl[ddmr_pkg::B_GLOBAL_MASK];
  assign restart_req = (reg_wr && reg_addr == ddmr_pkg::A_MODE &&
                        reg_wdata == ddmr_pkg::RESTART_CODE)
                       || (disable_d && !disable_pin);

  always_ff @(posedge clk) begin
    if (rst) begin
      disable_d <= 1'b0;
    end else if (ce) begin
      disable_d <= disable_pin;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_state <= ddmr_pkg::TX_STARTUP;
      start_cnt <= '0;
    end else if (ce) begin
      unique case (tx_state)
        ddmr_pkg::TX_STARTUP: begin
          start_cnt <= start_cnt + SW'(1);
          if (start_cnt == SW'(STARTUP_CYCLES - 1)) begin
            tx_state <= ddmr_pkg::TX_RUN;
          end
        end
        ddmr_pkg::TX_RUN: begin
          if (fault_cond) begin
            tx_state <= ddmr_pkg::TX_FAULT;
          end
        end
        ddmr_pkg::TX_FAULT: begin
          // Restart only once the cause is gone
          if (restart_req && !fault_cond) begin
            tx_state <= ddmr_pkg::TX_RUN;
          end
        end
      endcase
    end
  end

  assign next_shutdown = tx_state != ddmr_pkg::TX_RUN || disable_pin ||
                         !ctrl[ddmr_pkg::B_TX_EN] || !ctrl[ddmr_pkg::B_XCVR_ON];

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_shutdown_status_bit <= 1'b1;
    end else if (ce) begin
      tx_shutdown_status_bit <= next_shutdown;
    end
  end

  // ==========================================================
  // Monitor diode sampling and laser current report
  assign avg_bus.sample_stb = !tx_shutdown_status_bit &&
                              smp_cnt == 4'(ddmr_pkg::SAMPLE_CYC - 1);
  assign avg_bus.sample = monitor_diode_input;
  assign avg_bus.long_avg = ctrl[ddmr_pkg::B_AVG_CNT];

  always_ff @(posedge clk) begin
    if (rst) begin
      smp_cnt <= 4'h0;
    end else if (ce) begin
      if (tx_shutdown_status_bit || avg_bus.sample_stb) begin
        smp_cnt <= 4'h0;
      end else begin
        smp_cnt <= smp_cnt + 4'h1;
      end
    end
  end

  ddmr_txp_avg u_txp (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .port(avg_bus.avg)
  );

  logic [10:0] dc_code;
  logic [9:0] mod_code;
  logic [15:0] mod_dc;
  logic [15:0] mod_avg;
  assign dc_code = {1'b0, dc_current_setting} + ddmr_pkg::DC_OFFSET;
  assign mod_code = {1'b0, modulation_setting} + ddmr_pkg::MOD_OFFSET;
  assign mod_dc = (16'(mod_code) * 16'(ddmr_pkg::MOD_DC_NUM)) >> ddmr_pkg::MOD_DC_SHIFT;
  assign mod_avg = (16'(mod_code) * 16'(ddmr_pkg::MOD_AVG_NUM)) >> ddmr_pkg::MOD_AVG_SHIFT;

  always_ff @(posedge clk) begin
    if (rst) begin
      laser_current_report <= 12'h000;
    end else if (ce && avg_bus.result_stb && !tx_shutdown_status_bit) begin
      // Coefficient choices hold the report inside 17..1199 and 43..2056
      if (ctrl[ddmr_pkg::B_RPT_SEL]) begin
        laser_current_report <= 12'({5'h00, dc_code} + mod_avg);
      end else begin
        laser_current_report <= 12'({5'h00, dc_code} + mod_dc);
      end
    end
  end

  // ==========================================================
  // Slow results: 10 ms tick, optional fourfold average
  always_ff @(posedge clk) begin
    if (rst) begin
      upd_cnt <= '0;
      upd_tick <= 1'b0;
    end else if (ce) begin
      upd_tick <= upd_cnt == UW'(UPDATE_CYCLES - 1);
      upd_cnt <= (upd_cnt == UW'(UPDATE_CYCLES - 1)) ? '0 : upd_cnt + UW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avg_cnt <= 2'h0;
    end else if (ce && upd_tick) begin
      avg_cnt <= ctrl[ddmr_pkg::B_RES_AVG] ? avg_cnt + 2'h1 : 2'h0;
    end
  end

  for (genvar g = 0; g < ddmr_pkg::NUM_ADC; g++) begin : g_chan
    logic signed [18:0] total;
    assign total = acc[g] + 19'(latest[g]);

    always_ff @(posedge clk) begin
      if (rst) begin
        latest[g] <= 17'sh00000;
      end else if (ce && adc_valid && adc_chan == 3'(g)) begin
        latest[g] <= adc_data;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        acc[g] <= 19'sh00000;
        result[g] <= 16'h0000;
      end else if (ce && upd_tick) begin
        if (!ctrl[ddmr_pkg::B_RES_AVG]) begin
          acc[g] <= 19'sh00000;
          result[g] <= fit(19'(latest[g]), g);
        end else if (avg_cnt == ddmr_pkg::AVG_LAST) begin
          acc[g] <= 19'sh00000;
          result[g] <= fit(total >>> ddmr_pkg::AVG_SHIFT, g);
        end else begin
          acc[g] <= total;
        end
      end
    end
  end

  // ==========================================================
  // Loopback and squelch
  logic rx_src;
  logic tx_src;
  logic laser_on;
  assign rx_src = loop_ctrl[ddmr_pkg::B_LOOP_T2R] ? tx_input : rx_input;
  assign tx_src = loop_ctrl[ddmr_pkg::B_LOOP_R2T] ? rx_input : tx_input;
  assign laser_on = !next_shutdown &&
                    !(ctrl[ddmr_pkg::B_TX_SQ] && !tx_sig_present);

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_output <= 1'b0;
      laser_anode_out <= 1'b0;
      laser_cathode_out <= 1'b0;
    end else if (ce) begin
      rx_output <= rx_src && !(ctrl[ddmr_pkg::B_RX_SQ] && !rx_sig_present);
      laser_anode_out <= laser_on && tx_src;
      laser_cathode_out <= laser_on && !tx_src;
    end
  end

endmodule

// ---- design/ddmr_pkg.sv ----
// Package of constants for the diagnostics result reporting block
package ddmr_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 10;
  localparam int SAMPLE_NS = 100;
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam int UPDATE_MS = 10;
  localparam int UPDATE_CYC = UPDATE_MS * 1000000 / CLK_NS;
  localparam int STARTUP_US = 100;
  localparam int STARTUP_CYC = STARTUP_US * 1000 / CLK_NS;
  localparam logic [1:0] AVG_LAST = 2'h3;
  localparam int AVG_SHIFT = 2;
  localparam logic [8:0] TXP_SHORT_LAST = 9'h01f;
  localparam logic [8:0] TXP_LONG_LAST = 9'h0ff;
  localparam int TXP_SHORT_SHIFT = 5;
  localparam int TXP_LONG_SHIFT = 8;
  localparam logic [11:0] TXP_MIN = 12'h020;
  localparam logic [11:0] TXP_MAX = 12'hff0;

  // ==========================================================
  // Laser current arithmetic, in 58.5 uA codes
  localparam logic [10:0] DC_OFFSET = 11'h00c;
  localparam logic [9:0] MOD_OFFSET = 10'h010;
  localparam logic [5:0] MOD_DC_NUM = 6'h05;
  localparam int MOD_DC_SHIFT = 4;
  localparam logic [5:0] MOD_AVG_NUM = 6'h3e;
  localparam int MOD_AVG_SHIFT = 5;
  localparam logic [7:0] RESTART_CODE = 8'h68;

  // ==========================================================
  // Result slots
  localparam int NUM_ADC = 7;
  localparam int NUM_RES = 9;
  localparam int CH_DIE = 5;
  localparam int CH_REMOTE = 6;
  localparam int CH_RSSI = 4;
  localparam int RES_LASER = 7;
  localparam int RES_TXP = 8;

  // ==========================================================
  // Register map
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_FMASK1 = 8'h5c;
  localparam logic [7:0] A_FMASK2 = 8'h5d;
  localparam logic [7:0] A_RES_BASE = 8'h60;
  localparam logic [7:0] A_FSTAT1 = 8'h72;
  localparam logic [7:0] A_FSTAT2 = 8'h73;
  localparam logic [7:0] A_CTRL = 8'h74;
  localparam logic [7:0] A_DC_HI = 8'h75;
  localparam logic [7:0] A_DC_LO = 8'h76;
  localparam logic [7:0] A_MOD_HI = 8'h77;
  localparam logic [7:0] A_MOD_LO = 8'h78;
  localparam logic [7:0] A_LOOP = 8'h79;
  localparam logic [7:0] A_DDM_STAT = 8'h7a;

  // ==========================================================
  // Fields
  localparam int B_RPT_SEL = 0;
  localparam int B_AVG_CNT = 1;
  localparam int B_RES_AVG = 2;
  localparam int B_GLOBAL_MASK = 3;
  localparam int B_XCVR_ON = 4;
  localparam int B_TX_EN = 5;
  localparam int B_RX_SQ = 6;
  localparam int B_TX_SQ = 7;
  localparam int B_LOOP_T2R = 0;
  localparam int B_LOOP_R2T = 1;
  localparam int B_STRENGTH_FAIL = 0;
  localparam int B_SHDN = 1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] FMASK1_RST = 8'h70;
  localparam logic [7:0] FMASK2_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h30;
  localparam logic [7:0] LOOP_RST = 8'h00;
  localparam logic [9:0] DC_RST = 10'h000;
  localparam logic [8:0] MOD_RST = 9'h000;

  typedef enum logic [2:0] {
    TX_STARTUP = 3'b001,
    TX_RUN = 3'b010,
    TX_FAULT = 3'b100
  } ddmr_tx_state_t;

endpackage

// ---- design/ddmr_txp_avg.sv ----
// Monitor diode sample averager for the transmit power result
`timescale 1ns/1ps
module ddmr_txp_avg (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  ddmr_avg_if.avg port
);

  logic [19:0] sum;
  logic [8:0] cnt;
  logic [19:0] total;
  logic [11:0] mean;

  always_comb begin
    total = sum + {8'h00, port.sample};
    if (port.long_avg) begin
      mean = total[ddmr_pkg::TXP_LONG_SHIFT +: 12];
    end else begin
      mean = total[ddmr_pkg::TXP_SHORT_SHIFT +: 12];
    end
  end

  // ==========================================================
  // Accumulate and publish
  always_ff @(posedge clk) begin
    if (rst) begin
      sum <= 20'h00000;
      cnt <= 9'h000;
      port.result_stb <= 1'b0;
      port.result <= ddmr_pkg::TXP_MIN;
    end else if (ce) begin
      port.result_stb <= 1'b0;
      if (port.sample_stb) begin
        // A change to short depth mid-window ends the window early; a change to long extends it
        if (cnt >= (port.long_avg ? ddmr_pkg::TXP_LONG_LAST : ddmr_pkg::TXP_SHORT_LAST)) begin
          sum <= 20'h00000;
          cnt <= 9'h000;
          port.result_stb <= 1'b1;
          if (mean < ddmr_pkg::TXP_MIN) begin
            port.result <= ddmr_pkg::TXP_MIN;
          end else if (mean > ddmr_pkg::TXP_MAX) begin
            port.result <= ddmr_pkg::TXP_MAX;
          end else begin
            port.result <= mean;
          end
        end else begin
          sum <= total;
          cnt <= cnt + 9'h001;
        end
      end
    end
  end

endmodule

// ---- test/ddmr_monitor_asserts.sv ----
// Port-level assertions for the diagnostics reporting block
`timescale 1ns/1ps
module ddmr_monitor_asserts #(
  parameter int UPDATE_CYCLES = 20,
  parameter int STARTUP_CYCLES = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rssi_sourcing,
  input wire logic disable_pin,
  input wire logic laser_anode_out,
  input wire logic laser_cathode_out,
  input wire logic tx_shutdown_status_bit,
  input wire logic strength_low_fail_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ====
  // Strength fail flag
  sequence s_source;
    ce && rssi_sourcing;
  endsequence
  // Quiet cycles up to and including the read, so no new event sets the flag again
  sequence s_quiet_read;
    !rssi_sourcing [*3] ##0 (ce && reg_rd && reg_addr == ddmr_pkg::A_DDM_STAT);
  endsequence
  property p_flag_set;
    s_source |=> strength_low_fail_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("fail flag not set");
  property p_flag_hold;
    strength_low_fail_flag && !(reg_rd && reg_addr == ddmr_pkg::A_DDM_STAT)
      |=> strength_low_fail_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("fail flag dropped");
  property p_flag_clr;
    s_quiet_read |=> !strength_low_fail_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("fail flag not cleared");
  // ====
  // Laser outputs and shutdown
  property p_laser_excl;
    !(laser_anode_out && laser_cathode_out);
  endproperty
  a_laser_excl: assert property (p_laser_excl) else $error("laser pins both high");
  property p_dark;
    tx_shutdown_status_bit [*3] |-> !$past(laser_anode_out) && !$past(laser_cathode_out);
  endproperty
  a_dark: assert property (p_dark) else $error("laser driven while shut down");
  property p_disable;
    (ce && disable_pin) [*4] |-> tx_shutdown_status_bit;
  endproperty
  a_disable: assert property (p_disable) else $error("disable pin ignored");
  property p_startup;
    $fell(rst) |-> tx_shutdown_status_bit [*5];
  endproperty
  a_startup: assert property (p_startup) else $error("early start after reset");
  property p_rd_hold;
    ce && !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind ddmr_monitor ddmr_monitor_asserts #(
  .UPDATE_CYCLES(UPDATE_CYCLES),
  .STARTUP_CYCLES(STARTUP_CYCLES)
) u_asserts (.*);

// ---- test/ddmr_monitor_tb.sv ----
// Self-checking bench for the diagnostics reporting block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module ddmr_monitor_tb;
  typedef struct {logic [2:0] ch; logic [16:0] d; logic [15:0] e;} ddmr_row_t;
  logic clk, rst, ce, reg_wr, reg_rd, adc_valid, rssi_sourcing, disable_pin;
  logic tx_input, rx_input, tx_sig_present, rx_sig_present, rx_output;
  logic laser_anode_out, laser_cathode_out, tx_shutdown_status_bit, strength_low_fail_flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
  logic [2:0] adc_chan;
  logic signed [16:0] adc_data;
  logic [11:0] monitor_diode_input;
  logic [15:0] fault_ind, v;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  ddmr_row_t rows [7] = '{'{3'h0, 17'h1fffb, 16'h0000}, '{3'h1, 17'h01fff, 16'h0fff},
    '{3'h3, 17'h00abc, 16'h0abc}, '{3'h4, 17'h1ffff, 16'h0000},
    '{3'h5, 17'h1fe80, 16'hfe80}, '{3'h6, 17'h0ffff, 16'h7fff}, '{3'h5, 17'h10000, 16'h8000}};

  ddmr_monitor #(.UPDATE_CYCLES(20), .STARTUP_CYCLES(5)) DUT (.*);

  // ====
  // Drivers, all acting on the falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    tick(1);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd(a, d[15:8]);
    rd(a + 8'h01, d[7:0]);
  endtask
  task automatic adc(input logic [2:0] c, input logic [16:0] d);
    adc_chan = c;
    adc_data = d;
    adc_valid = 1'b1;
    tick(1);
    adc_valid = 1'b0;
  endtask
  // Long wait: a setting change may land mid-window, so two windows must pass
  task automatic las(input logic s, input logic [9:0] dc, input logic [8:0] md,
                     input logic [11:0] mdi, input logic [15:0] el, input logic [15:0] ep);
    wr(8'h74, {7'h18, s});
    wr(8'h75, {6'h00, dc[9:8]});
    wr(8'h76, dc[7:0]);
    wr(8'h77, {7'h00, md[8]});
    wr(8'h78, md[7:0]);
    monitor_diode_input = mdi;
    tick(700);
    rd16(8'h6e, v);
    `CHK("laser report", el, v)
    rd16(8'h70, v);
    `CHK("tx power", ep, v)
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ====
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      summarize();
    end
  end

  // ====
  // Main sequence
  initial begin
    {rst, ce, reg_wr, reg_rd, adc_valid, rssi_sourcing, disable_pin} = 7'h60;
    {tx_input, rx_input, tx_sig_present, rx_sig_present} = 4'h3;
    {reg_addr, reg_wdata, adc_chan, adc_data} = '0;
    monitor_diode_input = 12'h000;
    fault_ind = 16'h0000;
    tick(5);
    rst = 1'b0;
    `CHK("shutdown at reset", 1'b1, tx_shutdown_status_bit)
    rd(8'h74, b);
    `CHK("ctrl reset", 8'h30, b)
    rd(8'h5c, b);
    `CHK("mask one reset", 8'h70, b)
    rd(8'h10, b);
    `CHK("unmapped", 8'h00, b)
    $display("reset test done");
    foreach (rows[i]) begin
      adc(rows[i].ch, rows[i].d);
      tick(25);
      rd16(8'h60 + {4'h0, rows[i].ch, 1'b0}, v);
      `CHK("adc result", rows[i].e, v)
    end
    $display("result rows done");
    // Sample first, then enable averaging, so every tick of the window sees it
    adc(3'h3, 17'h00100);
    wr(8'h74, 8'h34);
    tick(100);
    rd16(8'h66, v);
    `CHK("fourfold mean", 16'h0100, v)
    adc(3'h3, 17'h00200);
    tick(25);
    rd16(8'h66, v);
    `CHK("fourfold pending", 1'b1, v !== 16'h0200)
    wr(8'h74, 8'h30);
    $display("averaging test done");
    las(1'b0, 10'h000, 9'h000, 12'h010, 16'h0011, 16'h0020);
    las(1'b0, 10'h3ff, 9'h1ff, 12'hfff, 16'h04af, 16'h0ff0);
    las(1'b1, 10'h000, 9'h000, 12'h123, 16'h002b, 16'h0123);
    las(1'b1, 10'h064, 9'h040, 12'h800, 16'h010b, 16'h0800);
    las(1'b0, 10'h064, 9'h040, 12'h020, 16'h0089, 16'h0020);
    $display("laser test done");
    disable_pin = 1'b1;
    tick(10);
    `CHK("shutdown", 1'b1, tx_shutdown_status_bit)
    `CHK("laser off", 2'b00, {laser_anode_out, laser_cathode_out})
    wr(8'h76, 8'h00);
    tick(700);
    rd16(8'h6e, v);
    `CHK("frozen report", 16'h0089, v)
    disable_pin = 1'b0;
    tick(20);
    `CHK("pin restart", 1'b0, tx_shutdown_status_bit)
    wr(8'h74, 8'h32);
    monitor_diode_input = 12'h456;
    tick(1000);
    rd16(8'h70, v);
    `CHK("long mean pending", 1'b1, v !== 16'h0456)
    tick(5200);
    rd16(8'h70, v);
    `CHK("long mean", 16'h0456, v)
    wr(8'h74, 8'h30);
    $display("freeze and mean done");
    fault_ind = 16'h0010;
    tick(10);
    `CHK("masked fault", 1'b0, tx_shutdown_status_bit)
    rd(8'h72, b);
    `CHK("status one", 8'h10, b & 8'h10)
    fault_ind = 16'h0100;
    tick(10);
    `CHK("fault shutdown", 1'b1, tx_shutdown_status_bit)
    rd(8'h73, b);
    `CHK("status two", 8'h01, b & 8'h01)
    fault_ind = 16'h0000;
    wr(8'h00, 8'h68);
    tick(20);
    `CHK("write restart", 1'b0, tx_shutdown_status_bit)
    fault_ind = 16'h0100;
    tick(3);
    fault_ind = 16'h0000;
    tick(10);
    `CHK("fault held", 1'b1, tx_shutdown_status_bit)
    disable_pin = 1'b1;
    tick(2);
    disable_pin = 1'b0;
    tick(10);
    `CHK("pin fault restart", 1'b0, tx_shutdown_status_bit)
    wr(8'h74, 8'h38);
    fault_ind = 16'h0001;
    tick(10);
    `CHK("global mask", 1'b0, tx_shutdown_status_bit)
    fault_ind = 16'h0000;
    wr(8'h74, 8'h30);
    $display("fault test done");
    rssi_sourcing = 1'b1;
    tick(1);
    rssi_sourcing = 1'b0;
    tick(3);
    `CHK("fail flag", 1'b1, strength_low_fail_flag)
    rd(8'h7a, b);
    `CHK("status fail bit", 1'b1, b[0])
    `CHK("flag cleared", 1'b0, strength_low_fail_flag)
    wr(8'h79, 8'h01);
    tx_input = 1'b1;
    tick(3);
    `CHK("loop high", 1'b1, rx_output)
    tx_input = 1'b0;
    tick(3);
    `CHK("loop low", 1'b0, rx_output)
    wr(8'h74, 8'h70);
    rx_sig_present = 1'b0;
    tx_input = 1'b1;
    tick(3);
    `CHK("rx squelch", 1'b0, rx_output)
    wr(8'h79, 8'h02);
    wr(8'h74, 8'hb0);
    tx_sig_present = 1'b0;
    tick(3);
    `CHK("tx squelch", 2'b00, {laser_anode_out, laser_cathode_out})
    tx_sig_present = 1'b1;
    tick(3);
    `CHK("laser loop", 2'b01, {laser_anode_out, laser_cathode_out})
    $display("flag and loop done");
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    `CHK("shutdown after reset", 1'b1, tx_shutdown_status_bit)
    rd(8'h00, b);
    `CHK("mode reset", 8'h00, b)
    rd(8'h79, b);
    `CHK("loop reset", 8'h00, b)
    $display("mid reset done");
    summarize();
  end
endmodule
